// >>> common/dtc_pkg.sv
/*
  Package for the output-code and trigger register bank: offsets, field
  positions, reset values, command codes, states and carrier structs.
  Assumes one clock domain and a synchronous active-high reset.
*/
package dtc_pkg;

  localparam int          DTC_AW            = 8;
  localparam int          DTC_DW            = 16;
  localparam int          DTC_CW            = 10;
  localparam logic [7:0]  DTC_OFF_DATA      = 8'h21;
  localparam logic [7:0]  DTC_OFF_GENCFG    = 8'hd1;
  localparam logic [7:0]  DTC_OFF_CFG2      = 8'hd2;
  localparam logic [7:0]  DTC_OFF_TRIG      = 8'hd3;
  localparam logic [7:0]  DTC_OFF_MHIGH     = 8'h25;
  localparam logic [7:0]  DTC_OFF_MLOW      = 8'h26;

  localparam logic [15:0] DTC_RST_DATA      = 16'h0000;
  localparam logic [15:0] DTC_RST_TRIG      = 16'h0008;
  localparam logic [15:0] DTC_RST_GENCFG    = 16'h0000;
  localparam logic [3:0]  DTC_UNLOCK_CODE   = 4'h5;
  localparam logic [3:0]  DTC_SWRST_IDLE    = 4'h8;
  localparam logic [3:0]  DTC_SWRST_GO      = 4'ha;
  localparam logic [1:0]  DTC_SHAPE_TRI     = 2'h0;
  localparam logic [1:0]  DTC_SHAPE_RISE    = 2'h1;
  localparam logic [1:0]  DTC_SHAPE_FALL    = 2'h2;
  localparam logic [1:0]  DTC_SHAPE_SQR     = 2'h3;

  // Trigger field positions
  localparam int          DTC_T_UNLK_HI     = 15;
  localparam int          DTC_T_UNLK_LO     = 12;
  localparam int          DTC_T_PIN_EN      = 10;
  localparam int          DTC_T_CFG_RST     = 9;
  localparam int          DTC_T_RUN         = 8;
  localparam int          DTC_T_MHIGH       = 7;
  localparam int          DTC_T_MLOW        = 6;
  localparam int          DTC_T_RELOAD      = 5;
  localparam int          DTC_T_PROG        = 4;
  // Configuration and code field positions
  localparam int          DTC_G_LOCK        = 13;
  localparam int          DTC_C2_RSV_HI     = 10;
  localparam int          DTC_C2_RSV_LO     = 6;
  localparam int          DTC_C2_IMP_HI     = 5;
  localparam int          DTC_CODE_HI       = 11;
  localparam int          DTC_CODE_LO       = 2;

  localparam int          DTC_NVM_WORDS     = 4;
  localparam int          DTC_NVM_AW        = 2;
  localparam logic [1:0]  DTC_NVM_LAST      = 2'h3;
  localparam logic [1:0]  DTC_NV_DATA       = 2'h0;
  localparam logic [1:0]  DTC_NV_CFG2       = 2'h1;
  localparam logic [1:0]  DTC_NV_MHIGH      = 2'h2;
  localparam logic [1:0]  DTC_NV_MLOW       = 2'h3;
  localparam logic [15:0] DTC_NV_INIT       = 16'h0000;
  localparam logic [15:0] DTC_STEP_DIV_DEF  = 16'h0010;

  typedef enum logic [1:0] {
    DTC_NV_IDLE   = 2'b00,
    DTC_NV_LOAD   = 2'b01,
    DTC_NV_STORE  = 2'b10
  } dtc_nv_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } dtc_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } dtc_rsp_t;

endpackage

// >>> rtl/dtc_nvm_mem.sv
/*
  Small word memory standing in for the nonvolatile store, with
  registered read data. Assumes the caller sequences one access a cycle.
*/
`timescale 1ns/10ps
module dtc_nvm_mem
  import dtc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  we,
  input  wire logic [DTC_NVM_AW-1:0] addr,
  input  wire logic [DTC_DW-1:0]     wdata,
  output logic      [DTC_DW-1:0]     rdata
);

  logic [DTC_DW-1:0] mem_r [DTC_NVM_WORDS];

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < DTC_NVM_WORDS; i++) begin
        mem_r[i] <= DTC_NV_INIT;
      end
    end else if (ce && we) begin
      mem_r[addr] <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= DTC_NV_INIT;
    end else if (ce) begin
      rdata <= mem_r[addr];
    end
  end

endmodule

// >>> rtl/dtc_wave_gen.sv
/*
  Waveform and margin stepper: moves the output code between the limit
  codes. Assumes limits are steady while running and step_div >= 1.
*/
`timescale 1ns/10ps
module dtc_wave_gen
  import dtc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              run,
  input  wire logic [1:0]        shape,
  input  wire logic              go_high,
  input  wire logic              go_low,
  input  wire logic [DTC_CW-1:0] lim_high,
  input  wire logic [DTC_CW-1:0] lim_low,
  input  wire logic [DTC_CW-1:0] step,
  input  wire logic [15:0]       step_div,
  input  wire logic              load,
  input  wire logic [DTC_CW-1:0] load_code,
  output logic      [DTC_CW-1:0] code_r
);

  logic [15:0] tick_cnt_r;
  logic        dir_up_r;
  logic        tick;

  function automatic logic [DTC_CW-1:0] step_to(input logic [DTC_CW-1:0] cur,
                                                 input logic [DTC_CW-1:0] tgt,
                                                 input logic [DTC_CW-1:0] stp);
    logic [DTC_CW:0] sum;
    sum = {1'b0, cur} + {1'b0, stp};
    if (cur < tgt) begin
      step_to = (sum >= {1'b0, tgt}) ? tgt : sum[DTC_CW-1:0];
    end else begin
      step_to = (cur - tgt <= stp) ? tgt : DTC_CW'(cur - stp);
    end
  endfunction

  assign tick = (tick_cnt_r == 16'h0000);

  always_ff @(posedge clock) begin
    if (rst) begin
      tick_cnt_r <= 16'h0000;
    end else if (ce) begin
      tick_cnt_r <= tick ? DTC_DW'(step_div - 16'h0001) : DTC_DW'(tick_cnt_r - 16'h0001);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_r   <= '0;
      dir_up_r <= 1'b1;
    end else if (ce) begin
      if (load) begin
        code_r <= load_code;
      end else if (tick && go_high) begin
        code_r <= step_to(code_r, lim_high, step);
      end else if (tick && go_low) begin
        code_r <= step_to(code_r, lim_low, step);
      end else if (tick && run) begin
        unique case (shape)
          DTC_SHAPE_TRI: begin
            if (dir_up_r) begin
              code_r <= step_to(code_r, lim_high, step);
              if (code_r == lim_high) dir_up_r <= 1'b0;
            end else begin
              code_r <= step_to(code_r, lim_low, step);
              if (code_r == lim_low) dir_up_r <= 1'b1;
            end
          end
          DTC_SHAPE_RISE: begin
            code_r <= (code_r == lim_high) ? lim_low : step_to(code_r, lim_high, step);
          end
          DTC_SHAPE_FALL: begin
            code_r <= (code_r == lim_low) ? lim_high : step_to(code_r, lim_low, step);
          end
          DTC_SHAPE_SQR: begin
            code_r <= (code_r == lim_high) ? lim_low : lim_high;
          end
        endcase
      end
    end
  end

endmodule

// >>> rtl/dtc_regs.sv
/*
  Register bank of a small voltage-output converter: output code word,
  address/input/calibration word and action strobe word, plus the
  configuration and limit words they act on, a memory sequencer and the
  waveform stepper. Assumes a serial-bus front end hands over one decoded
  register access per cycle on the same clock.
*/
`timescale 1ns/10ps
// Operation
// - The top two bits of the second configuration word are the low target address bits, reset 0.
// - Bits 10 to 6 of that word are reserved read-write bits resetting to zero with no effect.
// - Bits 5 to 0 hold the factory impedance error, 1% a step, lost once a host overwrites them.
// - Writing 0101 to the top four trigger bits unlocks writes; the field reads as zero.
// - A 1 in trigger bit 9 reloads every register with its factory reset value.
// - The raise command steps toward the upper limit and clears itself on reaching it.
// - The lower command steps toward the lower limit and clears itself on reaching it.
// - The program bit stores current settings, holding busy, and clears itself after.
// - The soft restart field reads 1000; writing 1010 reloads output words, defaults the rest.
// - The trigger word resets to 0008h and bit 11 is ignored on write.
// - A write to the output code word replaces the active code at once; it resets to zero.
// - The code is straight binary in bits 11 to 2; the 8-bit variant ignores the two lowest.
// - With the lock bit set no register changes until the unlock code is written.
// - Shape 00 triangle, 01 rising saw, 10 falling saw, 11 square.
module dtc_regs
  import dtc_pkg::*;
#(
  parameter int          CODE_BITS = 10,
  parameter logic [15:0] CFG2_RST  = 16'h0000
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire dtc_req_t          req,
  output dtc_rsp_t               rsp_r,
  output logic      [1:0]        target_addr_lo_r,
  output logic      [2:0]        input_pin_function_select_r,
  output logic                   input_pin_enable_r,
  output logic      [DTC_CW-1:0] active_code_r,
  output logic                   memory_busy_flag_r
);

  logic [15:0]       gencfg_r;
  logic [15:0]       cfg2_r;
  logic [15:0]       trig_r;
  logic [15:0]       data_r;
  logic [15:0]       mhigh_r;
  logic [15:0]       mlow_r;
  logic              locked;
  logic              wr_ok;
  logic              unlock_wr;
  logic              cfg_reset;
  logic              soft_restart_field;
  dtc_nv_state_t     nv_state_r;
  logic [1:0]        nv_idx_r;
  logic              nv_rd_vld_r;
  logic [1:0]        nv_rd_idx_r;
  logic [15:0]       nv_rdata;
  logic [15:0]       nv_wdata;
  logic              nv_we;
  logic [DTC_CW-1:0] gen_code;
  logic [DTC_CW-1:0] step;
  logic [DTC_CW-1:0] code_in;
  logic              code_load;

  function automatic logic [DTC_CW-1:0] code_of(input logic [15:0] w);
    logic [DTC_CW-1:0] c;
    c = w[DTC_CODE_HI:DTC_CODE_LO];
    if (CODE_BITS == 8) c[1:0] = 2'b00;
    code_of = c;
  endfunction

  function automatic logic wr_at(input dtc_req_t r, input logic [7:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction

  assign locked    = gencfg_r[DTC_G_LOCK];
  assign unlock_wr = wr_at(req, DTC_OFF_TRIG) &&
                     (req.wdata[DTC_T_UNLK_HI:DTC_T_UNLK_LO] == DTC_UNLOCK_CODE);
  assign wr_ok     = req.wr && (!locked || unlock_wr);
  assign cfg_reset = ce && wr_ok && wr_at(req, DTC_OFF_TRIG) && req.wdata[DTC_T_CFG_RST];
  assign soft_restart_field  = ce && wr_ok && wr_at(req, DTC_OFF_TRIG) &&
                     (req.wdata[3:0] == DTC_SWRST_GO);
  assign step      = DTC_CW'(gencfg_r[11:9]) + DTC_CW'(1);

  // Configuration word; unlock code also clears the lock bit
  always_ff @(posedge clock) begin
    if (rst || cfg_reset || soft_restart_field) begin
      gencfg_r <= DTC_RST_GENCFG;
    end else if (ce) begin
      if (wr_ok && wr_at(req, DTC_OFF_GENCFG)) begin
        gencfg_r <= req.wdata;
      end else if (unlock_wr) begin
        gencfg_r[DTC_G_LOCK] <= 1'b0;
      end
    end
  end

  // Second configuration word
  always_ff @(posedge clock) begin
    if (rst || cfg_reset) begin
      cfg2_r <= CFG2_RST;
    end else if (ce) begin
      if (wr_ok && !unlock_wr && wr_at(req, DTC_OFF_CFG2)) begin
        cfg2_r <= req.wdata;
      end else if (nv_rd_vld_r && nv_rd_idx_r == DTC_NV_CFG2) begin
        cfg2_r <= nv_rdata;
      end else if (soft_restart_field) begin
        cfg2_r[15:DTC_C2_RSV_LO] <= CFG2_RST[15:DTC_C2_RSV_LO];
      end
    end
  end

  // Limit words
  always_ff @(posedge clock) begin
    if (rst || cfg_reset) begin
      mhigh_r <= 16'h0000;
      mlow_r  <= 16'h0000;
    end else if (ce) begin
      if (wr_ok && wr_at(req, DTC_OFF_MHIGH)) mhigh_r <= req.wdata;
      if (wr_ok && wr_at(req, DTC_OFF_MLOW)) mlow_r <= req.wdata;
      if (nv_rd_vld_r && nv_rd_idx_r == DTC_NV_MHIGH) mhigh_r <= nv_rdata;
      if (nv_rd_vld_r && nv_rd_idx_r == DTC_NV_MLOW) mlow_r <= nv_rdata;
    end
  end

  // Output code word
  always_ff @(posedge clock) begin
    if (rst || cfg_reset) begin
      data_r <= DTC_RST_DATA;
    end else if (ce) begin
      if (wr_ok && wr_at(req, DTC_OFF_DATA)) begin
        data_r <= req.wdata;
      end else if (nv_rd_vld_r && nv_rd_idx_r == DTC_NV_DATA) begin
        data_r <= nv_rdata;
      end
    end
  end

  // Trigger word: strobes, self-clearing commands
  always_ff @(posedge clock) begin
    if (rst || cfg_reset) begin
      trig_r <= DTC_RST_TRIG;
    end else if (ce) begin
      if (wr_ok && wr_at(req, DTC_OFF_TRIG)) begin
        trig_r                   <= DTC_RST_TRIG;
        trig_r[DTC_T_PIN_EN]     <= req.wdata[DTC_T_PIN_EN];
        trig_r[DTC_T_RUN]        <= req.wdata[DTC_T_RUN];
        trig_r[DTC_T_MHIGH]      <= req.wdata[DTC_T_MHIGH];
        trig_r[DTC_T_MLOW]       <= req.wdata[DTC_T_MLOW];
        trig_r[DTC_T_RELOAD]     <= req.wdata[DTC_T_RELOAD] | trig_r[DTC_T_RELOAD];
        trig_r[DTC_T_PROG]       <= req.wdata[DTC_T_PROG] | trig_r[DTC_T_PROG];
        if (soft_restart_field) trig_r     <= DTC_RST_TRIG;
      end else begin
        if (gen_code == code_of(mhigh_r)) trig_r[DTC_T_MHIGH] <= 1'b0;
        if (gen_code == code_of(mlow_r)) trig_r[DTC_T_MLOW] <= 1'b0;
        // Clear with the last fetch so the idle state does not restart the load
        if (nv_state_r == DTC_NV_LOAD && nv_idx_r == DTC_NVM_LAST) begin
          trig_r[DTC_T_RELOAD] <= 1'b0;
        end
        if (nv_state_r == DTC_NV_STORE && nv_idx_r == DTC_NVM_LAST) begin
          trig_r[DTC_T_PROG] <= 1'b0;
        end
      end
    end
  end

  // Memory sequencer: load walks all words, store writes all words
  always_ff @(posedge clock) begin
    if (rst || cfg_reset) begin
      nv_state_r  <= DTC_NV_IDLE;
      nv_idx_r    <= 2'h0;
      nv_rd_vld_r <= 1'b0;
      nv_rd_idx_r <= 2'h0;
    end else if (ce) begin
      nv_rd_vld_r <= (nv_state_r == DTC_NV_LOAD);
      nv_rd_idx_r <= nv_idx_r;
      unique case (nv_state_r)
        DTC_NV_IDLE: begin
          nv_idx_r <= 2'h0;
          if (soft_restart_field || trig_r[DTC_T_RELOAD]) begin
            nv_state_r <= DTC_NV_LOAD;
          end else if (trig_r[DTC_T_PROG]) begin
            nv_state_r <= DTC_NV_STORE;
          end
        end
        DTC_NV_LOAD, DTC_NV_STORE: begin
          nv_idx_r <= nv_idx_r + 2'h1;
          if (nv_idx_r == DTC_NVM_LAST) nv_state_r <= DTC_NV_IDLE;
        end
        default: nv_state_r <= DTC_NV_IDLE;
      endcase
    end
  end

  always_comb begin
    unique case (nv_idx_r)
      DTC_NV_DATA:  nv_wdata = data_r;
      DTC_NV_CFG2:  nv_wdata = cfg2_r;
      DTC_NV_MHIGH: nv_wdata = mhigh_r;
      default:      nv_wdata = mlow_r;
    endcase
  end

  assign nv_we     = (nv_state_r == DTC_NV_STORE);
  assign code_load = (wr_ok && wr_at(req, DTC_OFF_DATA)) ||
                     (nv_rd_vld_r && nv_rd_idx_r == DTC_NV_DATA);
  assign code_in   = (wr_ok && wr_at(req, DTC_OFF_DATA)) ? code_of(req.wdata) :
                     code_of(nv_rdata);

  dtc_nvm_mem u_nvm (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .we    (nv_we),
    .addr  (nv_idx_r),
    .wdata (nv_wdata),
    .rdata (nv_rdata)
  );

  dtc_wave_gen u_wave (
    .clock     (clock),
    .rst       (rst || cfg_reset),
    .ce        (ce),
    .run       (trig_r[DTC_T_RUN]),
    .shape     (gencfg_r[15:14]),
    .go_high   (trig_r[DTC_T_MHIGH]),
    .go_low    (trig_r[DTC_T_MLOW]),
    .lim_high  (code_of(mhigh_r)),
    .lim_low   (code_of(mlow_r)),
    .step      (step),
    .step_div  (DTC_STEP_DIV_DEF),
    .load      (code_load),
    .load_code (code_in),
    .code_r    (gen_code)
  );

  // Read port and pin outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_r                       <= '0;
      target_addr_lo_r            <= 2'b00;
      input_pin_function_select_r <= 3'b000;
      input_pin_enable_r          <= 1'b0;
      active_code_r               <= '0;
      memory_busy_flag_r          <= 1'b0;
    end else if (ce) begin
      rsp_r.valid <= req.rd;
      unique case (req.addr)
        DTC_OFF_DATA:   rsp_r.rdata <= {4'h0, data_r[11:0] & 12'hffc};
        DTC_OFF_GENCFG: rsp_r.rdata <= gencfg_r;
        DTC_OFF_CFG2:   rsp_r.rdata <= cfg2_r;
        DTC_OFF_TRIG:   rsp_r.rdata <= {4'h0, 1'b0, trig_r[10:4], DTC_SWRST_IDLE};
        DTC_OFF_MHIGH:  rsp_r.rdata <= mhigh_r;
        DTC_OFF_MLOW:   rsp_r.rdata <= mlow_r;
        default:        rsp_r.rdata <= 16'h0000;
      endcase
      target_addr_lo_r            <= cfg2_r[15:14];
      input_pin_function_select_r <= cfg2_r[13:11];
      input_pin_enable_r          <= trig_r[DTC_T_PIN_EN];
      active_code_r               <= gen_code;
      memory_busy_flag_r          <= (nv_state_r != DTC_NV_IDLE) || nv_rd_vld_r;
    end
  end

  property p_lock_holds;
    @(posedge clock) disable iff (rst)
      ce && locked && req.wr && !unlock_wr && req.addr == DTC_OFF_DATA
      |=> $stable(data_r);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked write changed data");

  property p_unlock;
    @(posedge clock) disable iff (rst) ce && unlock_wr |=> !locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed");

  property p_trig_read;
    @(posedge clock) disable iff (rst)
      ce && req.rd && req.addr == DTC_OFF_TRIG
      |=> rsp_r.rdata[15:11] == 5'h00 && rsp_r.rdata[3:0] == DTC_SWRST_IDLE;
  endproperty
  a_trig_read: assert property (p_trig_read) else $error("trigger readback wrong");

  property p_cfg_reset;
    @(posedge clock) disable iff (rst) ce && cfg_reset |=> data_r == DTC_RST_DATA;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset missed");

  property p_data_load;
    @(posedge clock) disable iff (rst)
      ce && wr_ok && req.addr == DTC_OFF_DATA ##1 ce
      |=> active_code_r == $past(code_of(req.wdata), 2);
  endproperty
  a_data_load: assert property (p_data_load) else $error("code not applied");

  property p_prog_busy;
    @(posedge clock) disable iff (rst)
      ce && nv_state_r == DTC_NV_STORE |=> memory_busy_flag_r;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("busy flag low");

  property p_prog_done;
    @(posedge clock) disable iff (rst)
      $rose(trig_r[DTC_T_PROG]) |-> ##[1:12] !trig_r[DTC_T_PROG];
  endproperty
  a_prog_done: assert property (p_prog_done) else $error("program bit stuck");

  property p_reload_done;
    @(posedge clock) disable iff (rst)
      $rose(trig_r[DTC_T_RELOAD]) |-> ##[1:12] !trig_r[DTC_T_RELOAD];
  endproperty
  a_reload_done: assert property (p_reload_done) else $error("reload bit stuck");

  property p_mhigh_clear;
    @(posedge clock) disable iff (rst)
      ce && trig_r[DTC_T_MHIGH] && gen_code == code_of(mhigh_r) && !req.wr
      |=> !trig_r[DTC_T_MHIGH];
  endproperty
  a_mhigh_clear: assert property (p_mhigh_clear) else $error("raise bit not cleared");

  property p_mlow_clear;
    @(posedge clock) disable iff (rst)
      ce && trig_r[DTC_T_MLOW] && gen_code == code_of(mlow_r) && !req.wr
      |=> !trig_r[DTC_T_MLOW];
  endproperty
  a_mlow_clear: assert property (p_mlow_clear) else $error("lower bit not cleared");

  c_unlock: cover property (@(posedge clock) disable iff (rst) locked ##1 unlock_wr);
  c_prog:   cover property (@(posedge clock) disable iff (rst) $fell(trig_r[DTC_T_PROG]));
  c_run:    cover property (@(posedge clock) disable iff (rst) trig_r[DTC_T_RUN] ##5 ce);

endmodule

// >>> tb/dtc_host_model.sv
/*
  Host side model: issues one decoded register access at a time.
  Assumes the register bank answers reads within a few cycles.
*/
`timescale 1ns/10ps
module dtc_host_model
  import dtc_pkg::*;
(
  input  wire logic     clock,
  input  wire dtc_rsp_t rsp,
  output dtc_req_t      req
);
  initial req = '0;

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    while (rsp.valid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    d = (rsp.valid === 1'b1) ? rsp.rdata : 16'hxxxx;
  endtask
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench for the register bank: reset values, code word,
  lock, memory store/load, restarts and margin commands.
  Assumes default parameters and a host model driving req.
*/
`timescale 1ns/10ps
module testbench
  import dtc_pkg::*;
;
  logic              clock;
  logic              rst;
  logic              ce;
  dtc_req_t          req;
  dtc_rsp_t          rsp_r;
  logic [1:0]        taddr;
  logic [2:0]        pinsel;
  logic              pin_en;
  logic [DTC_CW-1:0] code;
  logic              busy;
  int                err_count;
  int                compares;
  logic              seen;

  dtc_regs u_dtc_regs (
    .clock(clock), .rst(rst), .ce(ce), .req(req), .rsp_r(rsp_r),
    .target_addr_lo_r(taddr), .input_pin_function_select_r(pinsel),
    .input_pin_enable_r(pin_en), .active_code_r(code), .memory_busy_flag_r(busy)
  );
  dtc_host_model u_dtc_host_model (.clock(clock), .rsp(rsp_r), .req(req));

  initial clock = 1'b0;
  always #2 clock = ~clock;

  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    u_dtc_host_model.rd(a, d);
    check(nm, d, e);
  endtask

  task automatic settle;
    repeat (2) @(negedge clock);
  endtask

  task automatic wait_nvm;
    seen = 1'b0;
    for (int n = 0; n < 60; n++) begin
      @(negedge clock);
      if (busy === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
  endtask

  task automatic t_reset_vals;
    rd_chk(DTC_OFF_TRIG, 16'h0008, "trig_rst");
    rd_chk(DTC_OFF_DATA, 16'h0000, "data_rst");
    rd_chk(DTC_OFF_CFG2, 16'h0000, "cfg2_rst");
    check("taddr_rst", 16'(taddr), 16'h0000);
  endtask

  task automatic t_code;
    u_dtc_host_model.wr(DTC_OFF_DATA, 16'h0ffc);
    settle();
    check("code_full", 16'(code), 16'h03ff);
    rd_chk(DTC_OFF_DATA, 16'h0ffc, "data_rb");
    u_dtc_host_model.wr(DTC_OFF_DATA, 16'h0003);
    settle();
    check("code_low", 16'(code), 16'h0000);
    ce = 1'b0;
    u_dtc_host_model.wr(DTC_OFF_DATA, 16'h0ffc);
    settle();
    check("code_frozen", 16'(code), 16'h0000);
    ce = 1'b1;
  endtask

  task automatic t_cfg2_trig;
    u_dtc_host_model.wr(DTC_OFF_CFG2, 16'he7c5);
    rd_chk(DTC_OFF_CFG2, 16'he7c5, "cfg2_rb");
    check("taddr", 16'(taddr), 16'h0003);
    check("pinsel", 16'(pinsel), 16'h0004);
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h5c00);
    rd_chk(DTC_OFF_TRIG, 16'h0408, "trig_rb");
    check("pin_en", 16'(pin_en), 16'h0001);
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h0000);
    rd_chk(DTC_OFF_TRIG, 16'h0008, "trig_idle");
  endtask

  task automatic t_lock;
    u_dtc_host_model.wr(DTC_OFF_GENCFG, 16'h2000);
    u_dtc_host_model.wr(DTC_OFF_DATA, 16'h0100);
    settle();
    check("code_locked", 16'(code), 16'h0000);
    u_dtc_host_model.wr(DTC_OFF_CFG2, 16'h0000);
    rd_chk(DTC_OFF_CFG2, 16'he7c5, "cfg2_locked");
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h5000);
    u_dtc_host_model.wr(DTC_OFF_DATA, 16'h0100);
    settle();
    check("code_unlocked", 16'(code), 16'h0040);
  endtask

  task automatic t_nvm;
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h0010);
    wait_nvm();
    check("prog_busy", 16'(seen), 16'h0001);
    rd_chk(DTC_OFF_TRIG, 16'h0008, "prog_clr");
    u_dtc_host_model.wr(DTC_OFF_DATA, 16'h0000);
    u_dtc_host_model.wr(DTC_OFF_CFG2, 16'h0000);
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h0020);
    wait_nvm();
    check("load_busy", 16'(seen), 16'h0001);
    rd_chk(DTC_OFF_TRIG, 16'h0008, "load_clr");
    check("code_load", 16'(code), 16'h0040);
    rd_chk(DTC_OFF_CFG2, 16'he7c5, "cfg2_load");
  endtask

  task automatic t_soft;
    u_dtc_host_model.wr(DTC_OFF_DATA, 16'h0200);
    u_dtc_host_model.wr(DTC_OFF_GENCFG, 16'hc000);
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h000a);
    wait_nvm();
    check("soft_code", 16'(code), 16'h0040);
    rd_chk(DTC_OFF_GENCFG, 16'h0000, "soft_gencfg");
  endtask

  task automatic t_margin(input logic [7:0] off, input logic [15:0] lim,
                          input logic [15:0] cmd);
    logic [15:0] d;
    u_dtc_host_model.wr(off, lim);
    u_dtc_host_model.wr(DTC_OFF_TRIG, cmd);
    for (int n = 0; n < 200; n++) begin
      u_dtc_host_model.rd(DTC_OFF_TRIG, d);
      if (d === 16'h0008) break;
    end
    check("margin_clr", d, 16'h0008);
    check("margin_code", 16'(code), 16'(lim[11:2]));
  endtask

  task automatic wait_code(input logic [DTC_CW-1:0] e, input string nm);
    int n;
    n = 0;
    while (code !== e && n < 200) begin
      @(negedge clock);
      n++;
    end
    check(nm, 16'(code), 16'(e));
  endtask

  // Limits left at 044h and 03ch by the margin scenarios
  task automatic t_wave(input logic [15:0] cfg);
    u_dtc_host_model.wr(DTC_OFF_GENCFG, cfg);
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h0100);
    wait_code(10'h044, "wave_high");
    wait_code(10'h03c, "wave_low");
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h0000);
    repeat (40) @(negedge clock);
    check("wave_stop", 16'(code), 16'h003c);
  endtask

  task automatic t_cfg_reset;
    u_dtc_host_model.wr(DTC_OFF_CFG2, 16'hffff);
    u_dtc_host_model.wr(DTC_OFF_TRIG, 16'h0200);
    settle();
    rd_chk(DTC_OFF_CFG2, 16'h0000, "cr_cfg2");
    rd_chk(DTC_OFF_DATA, 16'h0000, "cr_data");
    rd_chk(DTC_OFF_TRIG, 16'h0008, "cr_trig");
    check("cr_code", 16'(code), 16'h0000);
    check("cr_taddr", 16'(taddr), 16'h0000);
  endtask

  task automatic give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #20000;
    err_count++;
    give_verdict();
  end

  initial begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    ce = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    t_reset_vals();
    t_code();
    t_cfg2_trig();
    t_lock();
    t_nvm();
    t_soft();
    t_margin(DTC_OFF_MHIGH, 16'h0110, 16'h0080);
    t_margin(DTC_OFF_MLOW, 16'h00f0, 16'h0040);
    t_wave(16'h0000);
    t_wave(16'h4000);
    t_wave(16'h8000);
    t_wave(16'hc000);
    t_cfg_reset();
    give_verdict();
  end
endmodule
